// ==== logic/vrc_top.sv ====
// serial link engine and volatile read configuration top
`timescale 1ns/10ps
`include "vrc_cfg.svh"

// Functional notes
// - dummy cycles from config bits 7:4
// - codes 0000 and 1111 select default
// - bit 3 switches execute in place
// - feature digit 2/4 forces execute in place
// - wrap 00 wraps within 16 bytes
// - wrap 01 wraps within 32 bytes
// - wrap 10 wraps within 64 bytes
// - wrap 11 reads sequentially, default
// - start at address, return to block start
// - writes apply at once, register readable, both only with execute in place off
// - nonvolatile bits 2/3 select protocol
// - nonvolatile 15:12 loads dummy count
module vrc_top #(
    parameter int FEATURE_DIGIT = 0
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // serial link, on its own clock
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe_n,
    // memory array, on the link clock
    output logic [23:0] arr_addr,
    output logic arr_rd,
    input wire logic [7:0] arr_data,
    // nonvolatile straps
    input wire logic [15:0] nv_cfg,
    // configuration seen by the rest of the device
    output logic [7:0] cfg_byte,
    output logic [3:0] dummy_cycles,
    output logic execute_in_place_enable,
    output logic [1:0] wrap_mode,
    output logic proto_dual,
    output logic proto_quad
);
    import vrc_pkg::*;

    ////////////////////////////////////////////////////////////////
    // declarations
    localparam logic EXEC_FORCED = (FEATURE_DIGIT == 2) || (FEATURE_DIGIT == 4);

    vrc_frame_t s_reg;   // frame state
    vrc_frame_t s_next;  // frame next state
    vrc_wlink_t w_reg;   // write toggle state
    vrc_wlink_t w_next;  // write toggle next
    logic [7:0] cfg_reg; // clk_sys register
    logic [7:0] cfg_m;   // first sync stage
    logic [7:0] cfg_s;   // second sync stage
    logic [3:0] code_s;  // dummy code, link side
    logic [3:0] deff_s;  // effective dummies, link side
    logic [1:0] wrap_s;  // wrap field, link side
    logic exec_s;        // execute in place, link side
    logic [23:0] mask;   // in-block address mask
    logic [23:0] inc;    // address plus one
    logic [23:0] nxt;    // address after wrap
    logic [7:0] byte_in; // byte just shifted in

    ////////////////////////////////////////////////////////////////
    // register bank in the system domain
    vrc_cfg_bank u_bank (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .nv_cfg(nv_cfg),
        .wr_tgl(w_reg.tgl),
        .wr_data(w_reg.data),
        .cfg_reg(cfg_reg),
        .proto_dual(proto_dual),
        .proto_quad(proto_quad)
    );

    ////////////////////////////////////////////////////////////////
    // dummy code decode, both domains share it
    function automatic logic [3:0] vrc_dummy_eff(input logic [3:0] code);
        logic [3:0] r;
        r = code;
        if (code == `VRC_CODE_ZERO || code == `VRC_CODE_ONES) begin
            r = `VRC_DUMMY_DEF;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // system-side view of the configuration
    assign cfg_byte = cfg_reg;
    assign dummy_cycles = vrc_dummy_eff(cfg_reg[`VRC_DUMMY_MSB:`VRC_DUMMY_LSB]);
    // bit low enables, or the part is fixed in this mode
    assign execute_in_place_enable = EXEC_FORCED || !cfg_reg[`VRC_EXEC_BIT];
    assign wrap_mode = cfg_reg[`VRC_WRAP_MSB:`VRC_WRAP_LSB];

    ////////////////////////////////////////////////////////////////
    // config word into the link domain
    // written only between frames, so it is stable by the command end
    // reset while the link clock stands still, so the first frame decodes known values
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            cfg_m <= `VRC_CFG_RESET;
            cfg_s <= `VRC_CFG_RESET;
        end else begin
            cfg_m <= cfg_reg;
            cfg_s <= cfg_m;
        end
    end

    // link-side decode of the synchronised word
    assign code_s = cfg_s[`VRC_DUMMY_MSB:`VRC_DUMMY_LSB];
    assign deff_s = vrc_dummy_eff(code_s);
    assign wrap_s = cfg_s[`VRC_WRAP_MSB:`VRC_WRAP_LSB];
    assign exec_s = EXEC_FORCED || !cfg_s[`VRC_EXEC_BIT];

    ////////////////////////////////////////////////////////////////
    // next address, wrapping inside the aligned block
    always_comb begin
        unique case (wrap_s)
            `VRC_WRAP_16: mask = `VRC_MASK_16;
            `VRC_WRAP_32: mask = `VRC_MASK_32;
            `VRC_WRAP_64: mask = `VRC_MASK_64;
            `VRC_WRAP_SEQ: mask = `VRC_MASK_SEQ;
        endcase
        inc = s_reg.addr + 24'h00_0001;
        // upper bits hold, lower bits count and roll over
        nxt = (s_reg.addr & ~mask) | (inc & mask);
    end

    ////////////////////////////////////////////////////////////////
    // frame state machine
    always_comb begin
        s_next = s_reg;
        w_next = w_reg;
        byte_in = {s_reg.sh[6:0], mosi};
        s_next.ld = 1'b0;
        unique case (s_reg.st)
            // command byte, or address at once in execute in place
            VRC_HEAD: begin
                s_next.addr = {s_reg.addr[22:0], mosi};
                s_next.sh = byte_in;
                s_next.bits = s_reg.bits + 6'h01;
                if (exec_s && s_reg.bits == `VRC_ADDR_LAST) begin
                    // no command byte, straight to dummies
                    s_next.st = VRC_DUMMY;
                    s_next.dcnt = 4'h0;
                end else if (!exec_s && s_reg.bits == `VRC_CMD_LAST) begin
                    s_next.bits = 6'h00;
                    if (byte_in == `VRC_CMD_FREAD) begin
                        s_next.st = VRC_ADDR;
                    end else if (byte_in == `VRC_CMD_WRCFG) begin
                        s_next.st = VRC_WCFG;
                    end else if (byte_in == `VRC_CMD_RDCFG) begin
                        // register goes out from the next edge
                        s_next.st = VRC_RCFG;
                        s_next.sh = cfg_s;
                        s_next.drive = 1'b1;
                    end else begin
                        s_next.st = VRC_SKIP;
                    end
                end
            end
            // three address bytes, msb first
            VRC_ADDR: begin
                s_next.addr = {s_reg.addr[22:0], mosi};
                s_next.bits = s_reg.bits + 6'h01;
                if (s_reg.bits == `VRC_ADDR_LAST) begin
                    s_next.st = VRC_DUMMY;
                    s_next.dcnt = 4'h0;
                end
            end
            // dummy clocks, output still released
            VRC_DUMMY: begin
                s_next.dcnt = s_reg.dcnt + 4'h1;
                if (s_reg.dcnt == deff_s - 4'h1) begin
                    // last dummy edge fetches the first byte
                    s_next.st = VRC_DATA;
                    s_next.sh = arr_data;
                    s_next.addr = nxt;
                    s_next.ld = 1'b1;
                    s_next.drive = 1'b1;
                    s_next.bits = 6'h00;
                end
            end
            // shift a byte out, fetch the next at its end
            VRC_DATA: begin
                s_next.sh = {s_reg.sh[6:0], 1'b0};
                s_next.bits = s_reg.bits + 6'h01;
                if (s_reg.bits == `VRC_BYTE_LAST) begin
                    s_next.sh = arr_data;
                    s_next.addr = nxt;
                    s_next.ld = 1'b1;
                    s_next.bits = 6'h00;
                end
            end
            // one data byte for the register
            VRC_WCFG: begin
                s_next.sh = byte_in;
                s_next.bits = s_reg.bits + 6'h01;
                if (s_reg.bits == `VRC_BYTE_LAST) begin
                    // hand over by toggle, data held until next write
                    w_next.tgl = !w_reg.tgl;
                    w_next.data = byte_in;
                    s_next.st = VRC_SKIP;
                end
            end
            // register read repeats while clocks continue
            VRC_RCFG: begin
                s_next.sh = {s_reg.sh[6:0], 1'b0};
                s_next.bits = s_reg.bits + 6'h01;
                if (s_reg.bits == `VRC_BYTE_LAST) begin
                    s_next.sh = cfg_s;
                    s_next.bits = 6'h00;
                end
            end
            // rest of frame ignored
            VRC_SKIP: begin
                s_next.bits = 6'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // frame state, cleared while chip select is high
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            s_reg <= '{st: VRC_HEAD, bits: 6'h00, addr: 24'h00_0000, dcnt: 4'h0,
                       sh: 8'h00, drive: 1'b0, ld: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // write handover, cleared only by system reset
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            w_reg <= '{tgl: 1'b0, data: 8'h00};
        end else begin
            w_reg <= w_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // link and array outputs
    assign miso = s_reg.sh[7];
    assign miso_oe_n = !s_reg.drive;
    assign arr_addr = s_reg.addr;
    assign arr_rd = s_reg.ld;

    ////////////////////////////////////////////////////////////////
    // checks on the link side
    AST_DUMMY_LEN: assert property (@(posedge sclk) disable iff (cs_n)
        (s_reg.st == VRC_DATA && $past(s_reg.st) == VRC_DUMMY) |-> ($past(s_reg.dcnt) == deff_s - 4'h1))
        else $error("dummy count differs from configured value");
    AST_DEF_CODE: assert property (@(posedge sclk) disable iff (cs_n)
        (code_s == 4'h0 || code_s == 4'hF) |-> deff_s == 4'hA)
        else $error("default dummy code not mapped");
    AST_CODE_LIN: assert property (@(posedge sclk) disable iff (cs_n)
        (code_s != 4'h0 && code_s != 4'hF) |-> deff_s == code_s)
        else $error("dummy code not taken literally");
    AST_DRIVE_DATA: assert property (@(posedge sclk) disable iff (cs_n)
        $rose(s_reg.st == VRC_DATA) |-> !miso_oe_n ##1 !miso_oe_n)
        else $error("output not driven after dummies");
    AST_WRAP16: assert property (@(posedge sclk) disable iff (cs_n)
        (arr_rd && wrap_s == 2'h0) |-> arr_addr[23:4] == $past(arr_addr[23:4]))
        else $error("16-byte wrap left its block");
    AST_WRAP32: assert property (@(posedge sclk) disable iff (cs_n)
        (arr_rd && wrap_s == 2'h1) |-> arr_addr[23:5] == $past(arr_addr[23:5]))
        else $error("32-byte wrap left its block");
    AST_WRAP64: assert property (@(posedge sclk) disable iff (cs_n)
        (arr_rd && wrap_s == 2'h2) |-> arr_addr[23:6] == $past(arr_addr[23:6]))
        else $error("64-byte wrap left its block");
    AST_SEQ: assert property (@(posedge sclk) disable iff (cs_n)
        (arr_rd && wrap_s == 2'h3) |-> arr_addr == 24'($past(arr_addr) + 24'h00_0001))
        else $error("sequential read skipped an address");
    AST_WRAP_RET: assert property (@(posedge sclk) disable iff (cs_n)
        (arr_rd && wrap_s != 2'h3 && ($past(arr_addr) & mask) == mask) |-> (arr_addr & mask) == 24'h00_0000)
        else $error("wrap did not return to block start");

    // checks on the system side
    AST_EXEC_FORCE: assert property (@(posedge clk_sys) disable iff (!resetn)
        EXEC_FORCED |-> execute_in_place_enable)
        else $error("fixed part left execute in place");
    AST_EXEC_BIT: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!EXEC_FORCED && $changed(cfg_reg[3])) |-> execute_in_place_enable == !cfg_reg[3])
        else $error("execute in place does not follow bit 3");

endmodule

// ==== logic/vrc_cfg.svh ====
// constants for the volatile read configuration block
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH

// volatile register field positions
`define VRC_DUMMY_MSB 7
`define VRC_DUMMY_LSB 4
`define VRC_EXEC_BIT 3
`define VRC_WRAP_MSB 1
`define VRC_WRAP_LSB 0

// wrap field codes
`define VRC_WRAP_16 2'h0
`define VRC_WRAP_32 2'h1
`define VRC_WRAP_64 2'h2
`define VRC_WRAP_SEQ 2'h3

// in-block address masks per wrap size
`define VRC_MASK_16 24'h00_000F
`define VRC_MASK_32 24'h00_001F
`define VRC_MASK_64 24'h00_003F
`define VRC_MASK_SEQ 24'hFF_FFFF

// dummy count codes that select the default
`define VRC_CODE_ZERO 4'h0
`define VRC_CODE_ONES 4'hF
`define VRC_DUMMY_DEF 4'hA

// nonvolatile field positions and reset value
`define VRC_NV_DUMMY_MSB 15
`define VRC_NV_DUMMY_LSB 12
`define VRC_NV_EXEC_MSB 11
`define VRC_NV_EXEC_LSB 9
`define VRC_NV_EXEC_OFF 3'h7
`define VRC_NV_QUAD_BIT 3
`define VRC_NV_DUAL_BIT 2
`define VRC_NV_RESET 16'hFFFF

// volatile register value before the nonvolatile copy loads
`define VRC_CFG_RESET 8'hFB

// serial command codes, values are arbitrary
`define VRC_CMD_WRCFG 8'hA1
`define VRC_CMD_RDCFG 8'hA5
`define VRC_CMD_FREAD 8'hAB

// serial field lengths, as last bit index
`define VRC_CMD_LAST 6'h07
`define VRC_ADDR_LAST 6'h17
`define VRC_BYTE_LAST 6'h07

// clk_sys cycles to let the strap synchroniser fill
`define VRC_LOAD_WAIT 2'h2

`endif

// ==== logic/vrc_pkg.sv ====
// types shared by the volatile read configuration block
package vrc_pkg;

    // serial frame states
    typedef enum logic [2:0] {
        VRC_HEAD, VRC_ADDR, VRC_DUMMY, VRC_DATA, VRC_WCFG, VRC_RCFG, VRC_SKIP
    } vrc_state_t;

    // per-frame link state, cleared while chip select is high
    typedef struct packed {
        vrc_state_t st;
        logic [5:0] bits;
        logic [23:0] addr;
        logic [3:0] dcnt;
        logic [7:0] sh;
        logic drive;
        logic ld;
    } vrc_frame_t;

    // link state that outlives a frame: write toggle and its data
    typedef struct packed {
        logic tgl;
        logic [7:0] data;
    } vrc_wlink_t;

    // clk_sys side state of the register bank
    typedef struct packed {
        logic [7:0] cfg;
        logic [15:0] nv_m;
        logic [15:0] nv_s;
        logic [2:0] tgl_s;
        logic [1:0] wait_cnt;
        logic loaded;
        logic dual;
        logic quad;
    } vrc_bank_t;

endpackage

// ==== logic/vrc_cfg_bank.sv ====
// clk_sys side volatile register, strap load and write capture
`timescale 1ns/10ps
`include "vrc_cfg.svh"

module vrc_cfg_bank (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // nonvolatile straps, asynchronous pins
    input wire logic [15:0] nv_cfg,
    // write event from the link domain
    input wire logic wr_tgl,
    input wire logic [7:0] wr_data,
    // register contents and protocol
    output logic [7:0] cfg_reg,
    output logic proto_dual,
    output logic proto_quad
);
    import vrc_pkg::*;

    vrc_bank_t b_reg;  // all state
    vrc_bank_t b_next; // next state
    logic wr_evt;      // toggle edge seen
    logic ld_evt;      // strap load moment

    ////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        b_next = b_reg;
        // straps and toggle pass two flops before use
        b_next.nv_m = nv_cfg;
        b_next.nv_s = b_reg.nv_m;
        b_next.tgl_s = {b_reg.tgl_s[1:0], wr_tgl};
        wr_evt = b_reg.loaded && (b_reg.tgl_s[2] != b_reg.tgl_s[1]);
        ld_evt = !b_reg.loaded && (b_reg.wait_cnt == `VRC_LOAD_WAIT);
        // wait for the synchroniser to fill after release
        if (!b_reg.loaded) begin
            b_next.wait_cnt = b_reg.wait_cnt + 2'h1;
        end
        // power-on copy from the nonvolatile straps
        if (ld_evt) begin
            b_next.loaded = 1'b1;
            b_next.cfg[`VRC_DUMMY_MSB:`VRC_DUMMY_LSB] = b_reg.nv_s[`VRC_NV_DUMMY_MSB:`VRC_NV_DUMMY_LSB];
            b_next.cfg[`VRC_EXEC_BIT] = (b_reg.nv_s[`VRC_NV_EXEC_MSB:`VRC_NV_EXEC_LSB] == `VRC_NV_EXEC_OFF);
            b_next.quad = !b_reg.nv_s[`VRC_NV_QUAD_BIT];
            b_next.dual = !b_reg.nv_s[`VRC_NV_DUAL_BIT] && b_reg.nv_s[`VRC_NV_QUAD_BIT];
        end
        // a write takes effect at once, reserved bit stays zero
        if (wr_evt) begin
            b_next.cfg = {wr_data[7:3], 1'b0, wr_data[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            b_reg <= '{cfg: `VRC_CFG_RESET, nv_m: `VRC_NV_RESET, nv_s: `VRC_NV_RESET,
                       tgl_s: 3'h0, wait_cnt: 2'h0, loaded: 1'b0, dual: 1'b0, quad: 1'b0};
        end else begin
            b_reg <= b_next;
        end
    end

    // outputs straight from flops
    assign cfg_reg = b_reg.cfg;
    assign proto_dual = b_reg.dual;
    assign proto_quad = b_reg.quad;

    ////////////////////////////////////////////////////////////////
    // checks
    AST_WRITE_APPLY: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_evt |=> (cfg_reg[7:3] == $past(wr_data[7:3])) && (cfg_reg[1:0] == $past(wr_data[1:0])))
        else $error("config write not applied next cycle");
    AST_NV_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
        ld_evt && !wr_evt |=> cfg_reg[7:4] == $past(b_reg.nv_s[15:12]))
        else $error("power-on dummy count not copied");
    AST_PROTO: assert property (@(posedge clk_sys) disable iff (!resetn)
        ld_evt |=> (proto_quad == !$past(b_reg.nv_s[3])) && !(proto_quad && proto_dual))
        else $error("protocol selection wrong");

endmodule

// ==== verif/vrc_host.sv ====
// host-side serial model driving the link of the configuration block
`timescale 1ns/10ps

module vrc_host (
    // serial link to the device
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    // 30 ns period, 33 MHz, stays below every single-line limit even at one dummy; no quad reads issued
    localparam time HALF = 15;
    logic [7:0] rx_q [$]; // bytes shifted in during this frame
    int oe_early; // edges where the device drove before its data phase
    int oe_late; // edges where the device let go during its data phase
    logic smp; // miso just before the last rising edge
    logic oe_smp; // miso_oe_n just before the last rising edge

    ////////////////////////////////////////////////////////////////
    // link idles deselected with the clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // one rising edge; miso is taken just before it, as the device launched it on the previous one
    task automatic edge_bit(input logic b);
        mosi = b;
        #HALF;
        // a released line reads as the inverse of the last sample, never a stale level
        smp = (miso_oe_n === 1'b0) ? miso : ~smp;
        oe_smp = miso_oe_n;
        sclk = 1'b1;
        #HALF;
        sclk = 1'b0;
    endtask

    // one frame: nh header bits msb first, nd dummy edges, nb bytes read back
    task automatic frame(input logic [31:0] head, input int nh, input int nd, input int nb);
        logic [7:0] b;
        rx_q.delete();
        oe_early = 0;
        oe_late = 0;
        cs_n = 1'b0;
        for (int i = nh - 1; i >= 0; i--) begin
            edge_bit(head[i]);
            oe_early += int'(oe_smp !== 1'b1);
        end
        // dummies and data carry a toggling pattern, never a stale level
        for (int i = 0; i < nd; i++) begin
            edge_bit(~mosi);
            oe_early += int'(oe_smp !== 1'b1);
        end
        for (int k = 0; k < nb; k++) begin
            for (int i = 7; i >= 0; i--) begin
                edge_bit(~mosi);
                b[i] = smp;
                oe_late += int'(oe_smp !== 1'b0);
            end
            rx_q.push_back(b);
        end
        #HALF;
        cs_n = 1'b1;
        mosi = ~mosi; // released line shows no stale value
        #(4 * HALF);
    endtask
endmodule

// ==== verif/vrc_top_tb.sv ====
// self-checking bench for the volatile read configuration block
`timescale 1ns/10ps
`include "vrc_cfg.svh"

module vrc_top_tb;
    // clock, reset and straps
    logic clk_sys;
    logic resetn;
    logic [15:0] nv_cfg;
    // link and array
    logic sclk, cs_n, mosi, miso, miso_oe_n, arr_rd;
    logic [23:0] arr_addr;
    logic [7:0] arr_data, cfg_byte;
    // configuration outputs
    logic [3:0] dummy_cycles;
    logic [1:0] wrap_mode;
    logic exec_en, exec_forced, proto_dual, proto_quad;
    int n_fail = 0;
    int n_tests = 0;
    int n_rd = 0; // array fetches seen in the current read

    ////////////////////////////////////////////////////////////////
    // array content is a fixed function of the byte address
    assign arr_data = arr_addr[7:0] ^ 8'hC3;

    // count fetch pulses on the link clock
    always @(posedge sclk) begin
        if (arr_rd === 1'b1) begin
            n_rd++;
        end
    end

    vrc_top #(.FEATURE_DIGIT(0)) vrc_top_i (
        .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_data(arr_data), .nv_cfg(nv_cfg),
        .cfg_byte(cfg_byte), .dummy_cycles(dummy_cycles), .execute_in_place_enable(exec_en),
        .wrap_mode(wrap_mode), .proto_dual(proto_dual), .proto_quad(proto_quad)
    );
    // a part whose feature digit forces execute in place, on the same link
    vrc_top #(.FEATURE_DIGIT(2)) vrc_top_f_i (
        .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(),
        .miso_oe_n(), .arr_addr(), .arr_rd(), .arr_data(arr_data), .nv_cfg(nv_cfg),
        .cfg_byte(), .dummy_cycles(), .execute_in_place_enable(exec_forced),
        .wrap_mode(), .proto_dual(), .proto_quad()
    );
    vrc_host vrc_host_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n));

    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // reset with given straps, then let the load land
    task automatic do_reset(input logic [15:0] nv);
        @(negedge clk_sys);
        resetn = 1'b0;
        nv_cfg = nv;
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (8) @(negedge clk_sys);
    endtask

    // serial register write, then time for the crossing
    task automatic wr_cfg(input logic [7:0] v);
        vrc_host_i.frame({16'h0000, `VRC_CMD_WRCFG, v}, 16, 0, 0);
        repeat (8) @(negedge clk_sys);
    endtask

    // fast read with expected bytes walked through the wrap block
    task automatic rd_check(input logic [23:0] a, input int nd, input int nb, input logic [1:0] w, input logic xp);
        logic [23:0] m;
        logic [23:0] p;
        m = (w == 2'h3) ? 24'hFF_FFFF : (24'h00_0010 << w) - 24'h00_0001;
        p = a;
        n_rd = 0;
        if (xp) begin
            vrc_host_i.frame({8'h00, a}, 24, nd, nb);
        end else begin
            vrc_host_i.frame({`VRC_CMD_FREAD, a}, 32, nd, nb);
        end
        check(vrc_host_i.oe_early, 0, "drive before data");
        for (int k = 0; k < nb; k++) begin
            check(vrc_host_i.rx_q[k], p[7:0] ^ 8'hC3, "read byte");
            p = (p & ~m) | ((p + 24'h00_0001) & m);
        end
        check(vrc_host_i.oe_late, 0, "drive lost in data");
        check(n_rd, nb, "array fetches");
    endtask

    ////////////////////////////////////////////////////////////////
    // power-on load from four strap settings, the last with both protocol bits cleared
    task automatic t_power();
        logic [15:0] nv [4] = '{16'h3FF7, 16'h01FF, 16'hFFFB, 16'h3FF3};
        logic [7:0] cf [4] = '{8'h3B, 8'h03, 8'hFB, 8'h3B};
        logic [3:0] dc [4] = '{4'h3, 4'hA, 4'hA, 4'h3};
        logic [2:0] md [4] = '{3'h2, 3'h4, 3'h1, 3'h2};
        for (int i = 0; i < 4; i++) begin
            do_reset(nv[i]);
            check(cfg_byte, cf[i], "loaded config");
            check(dummy_cycles, dc[i], "loaded dummies");
            check({exec_en, proto_quad, proto_dual}, md[i], "power-on modes");
            check(exec_forced, 1'b1, "forced execute in place");
        end
        $display("t_power done");
    endtask

    // write, read back, unknown command
    task automatic t_regs();
        wr_cfg(8'h5F);
        check(cfg_byte, 8'h5B, "written config");
        check({dummy_cycles, wrap_mode, exec_en}, {4'h5, 2'h3, 1'b0}, "written fields");
        check(exec_forced, 1'b1, "forced after write");
        vrc_host_i.frame({24'h00_0000, `VRC_CMD_RDCFG}, 8, 0, 2);
        check({vrc_host_i.rx_q[0], vrc_host_i.rx_q[1]}, 16'h5B5B, "read back");
        check(vrc_host_i.oe_early + vrc_host_i.oe_late, 0, "read drive");
        vrc_host_i.frame(32'h0000_0000, 8, 0, 2);
        check(vrc_host_i.oe_late, 16, "unknown command drive");
        $display("t_regs done");
    endtask

    // dummy counts at both ends and both default codes
    task automatic t_dummy();
        logic [3:0] code [4] = '{4'h1, 4'hE, 4'h0, 4'hF};
        for (int i = 0; i < 4; i++) begin
            wr_cfg({code[i], 4'hB});
            rd_check(24'h01_2345, (code[i] == 4'h0 || code[i] == 4'hF) ? 10 : int'(code[i]), 2, 2'h3, 1'b0);
        end
        $display("t_dummy done");
    endtask

    // every wrap mode from a start near the top of a 64-byte block
    task automatic t_wrap();
        for (int w = 0; w < 4; w++) begin
            wr_cfg(8'h28 + 8'(w));
            rd_check(24'h12_343D, 2, 6, w[1:0], 1'b0);
        end
        $display("t_wrap done");
    endtask

    // execute in place: address-only frames
    task automatic t_exec();
        wr_cfg(8'h23);
        check(exec_en, 1'b1, "execute in place on");
        vrc_host_i.frame(32'h0000_0000, 8, 0, 0); // lets the link side pick up the change
        rd_check(24'h00_0A50, 2, 3, 2'h3, 1'b1);
        $display("t_exec done");
    endtask

    ////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic end_sim();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        resetn = 1'b0;
        nv_cfg = 16'hFFFF;
        t_power();
        t_regs();
        t_dummy();
        t_wrap();
        t_exec();
        end_sim();
    end

    // watchdog: the whole sequence needs well under a millisecond
    initial begin
        #1_000_000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
